/* core/tcc_pkg.sv */
package tcc_pkg;
    localparam logic [7:0] OFS_CTRL_A = 8'h00;
    localparam logic [7:0] OFS_CTRL_B = 8'h04;
    localparam logic [7:0] OFS_CNT_LO = 8'h08;
    localparam logic [7:0] OFS_CNT_HI = 8'h0c;
    localparam logic [7:0] OFS_MATCH_A = 8'h10;
    localparam logic [7:0] OFS_MATCH_B = 8'h14;
    localparam logic [7:0] OFS_FLAGS = 8'h18;
    localparam logic [7:0] OFS_IRQ_EN = 8'h1c;
    localparam int CA_CLEAR = 0;
    localparam int CA_CAPTURE = 1;
    localparam int CA_COMPARATOR = 2;
    localparam int CA_EDGE = 3;
    localparam int CA_WIDE = 4;
    localparam int CA_W = 5;
    localparam int CB_CS_LSB = 0;
    localparam int CB_FILTER = 3;
    localparam int CB_W = 4;
    localparam int FL_OVERFLOW = 0;
    localparam int FL_MATCH_A = 1;
    localparam int FL_MATCH_B = 2;
    localparam int FL_CAPTURE = 3;
    localparam int FL_W = 4;
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_SYS = 3'h1;
    localparam logic [2:0] CS_PRE_FIRST = 3'h2;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    localparam logic [7:0] MAX8 = 8'hff;
    localparam logic [15:0] MAX16 = 16'hffff;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_CNT = 16'h0000;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam int FILTER_SAMPLES = 4;
    localparam int N_PINS = 3;
    localparam int PIN_EXT = 0;
    localparam int PIN_CAPTURE = 1;
    localparam int PIN_COMPARATOR = 2;
endpackage : tcc_pkg

/* core/tcc_timer.sv */
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
module tcc_timer #(
    parameter int PRESC_TAPS = 4
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [PRESC_TAPS-1:0] presc_tick,
    input wire logic ext_count_pin,
    input wire logic capture_pin,
    input wire logic comparator_out,
    input wire logic [tcc_pkg::FL_W-1:0] irq_ack,
    output logic [tcc_pkg::FL_W-1:0] irq_req
);

    logic [tcc_pkg::CA_W-1:0] ctrl_a_reg;
    logic [tcc_pkg::CB_W-1:0] ctrl_b_reg;
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic [7:0] match_a_reg;
    logic [7:0] match_b_reg;
    logic [7:0] temp_reg;
    logic [tcc_pkg::FL_W-1:0] flag_reg;
    logic [tcc_pkg::FL_W-1:0] flag_next;
    logic [tcc_pkg::FL_W-1:0] irq_en_reg;
    logic [tcc_pkg::FL_W-1:0] irq_req_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic block_reg;

    logic [tcc_pkg::N_PINS-1:0] pin_raw;
    logic [tcc_pkg::N_PINS-1:0] sync1_reg;
    logic [tcc_pkg::N_PINS-1:0] sync2_reg;
    logic ext_prev_reg;
    logic [tcc_pkg::FILTER_SAMPLES-2:0] filt_hist_reg;
    logic filt_out_reg;
    logic trig_prev_reg;

    // control decode
    logic clear_on_match_sel;
    logic capture_mode_en;
    logic comparator_trigger_sel;
    logic capture_rise_sel;
    logic wide_count_sel;
    logic [2:0] clock_select;
    logic noise_filter_en;
    logic wide_capture;
    logic ctc_mode;

    // bus decode
    logic setup;
    logic access_done;
    logic wr;
    logic rd_setup;
    logic addr_hit;
    logic [31:0] rd_word;
    logic [7:0] wbyte;
    logic cnt_wr;

    // event terms
    logic timer_tick;
    logic ext_rise;
    logic ext_fall;
    logic trig_sync;
    logic trig_level;
    logic trig_rise;
    logic trig_fall;
    logic cap_fire;
    logic ovf_set;
    logic eq_a;
    logic eq_b;
    logic match_a_set;
    logic match_b_set;
    logic [tcc_pkg::FL_W-1:0] flag_set;
    logic [tcc_pkg::FL_W-1:0] flag_w1c;

    assign clear_on_match_sel = ctrl_a_reg[tcc_pkg::CA_CLEAR];
    assign capture_mode_en = ctrl_a_reg[tcc_pkg::CA_CAPTURE];
    assign comparator_trigger_sel = ctrl_a_reg[tcc_pkg::CA_COMPARATOR];
    assign capture_rise_sel = ctrl_a_reg[tcc_pkg::CA_EDGE];
    assign wide_count_sel = ctrl_a_reg[tcc_pkg::CA_WIDE];
    assign clock_select = ctrl_b_reg[tcc_pkg::CB_CS_LSB +: 3];
    assign noise_filter_en = ctrl_b_reg[tcc_pkg::CB_FILTER];
    assign wide_capture = capture_mode_en & wide_count_sel;
    assign ctc_mode = clear_on_match_sel & ~capture_mode_en
        & ~wide_count_sel;

    // ---------------- apb slave ----------------
    // one wait-free access cycle: pready rises on the cycle after setup
    assign setup = psel & ~penable;
    assign access_done = psel & penable & pready_reg;
    assign wr = access_done & pwrite;
    assign rd_setup = setup & ~pwrite;
    assign wbyte = pwdata[7:0];
    assign cnt_wr = wr & (paddr == tcc_pkg::OFS_CNT_LO);

    always_comb begin
        rd_word = tcc_pkg::RST_WORD;
        addr_hit = 1'b1;
        case (paddr)
            tcc_pkg::OFS_CTRL_A: begin
                rd_word[tcc_pkg::CA_W-1:0] = ctrl_a_reg;
            end
            tcc_pkg::OFS_CTRL_B: begin
                rd_word[tcc_pkg::CB_W-1:0] = ctrl_b_reg;
            end
            tcc_pkg::OFS_CNT_LO: begin
                rd_word[7:0] = cnt_reg[7:0];
            end
            tcc_pkg::OFS_CNT_HI: begin
                rd_word[7:0] = temp_reg;
            end
            tcc_pkg::OFS_MATCH_A: begin
                rd_word[7:0] = match_a_reg;
            end
            tcc_pkg::OFS_MATCH_B: begin
                // compare value is static, so only capture needs temp
                rd_word[7:0] = wide_capture ? temp_reg : match_b_reg;
            end
            tcc_pkg::OFS_FLAGS: begin
                rd_word[tcc_pkg::FL_W-1:0] = flag_reg;
            end
            tcc_pkg::OFS_IRQ_EN: begin
                rd_word[tcc_pkg::FL_W-1:0] = irq_en_reg;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= tcc_pkg::RST_WORD;
        end else begin
            pready_reg <= setup;
            pslverr_reg <= setup & ~addr_hit;
            if (rd_setup) begin
                prdata_reg <= rd_word;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl_a_reg <= '0;
            ctrl_b_reg <= '0;
            irq_en_reg <= '0;
        end else if (wr) begin
            case (paddr)
                tcc_pkg::OFS_CTRL_A: begin
                    // a source switch may fake an edge; software clears
                    ctrl_a_reg <= pwdata[tcc_pkg::CA_W-1:0];
                end
                tcc_pkg::OFS_CTRL_B: begin
                    ctrl_b_reg <= pwdata[tcc_pkg::CB_W-1:0];
                end
                tcc_pkg::OFS_IRQ_EN: begin
                    irq_en_reg <= pwdata[tcc_pkg::FL_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ---------------- pin synchronisers ----------------
    assign pin_raw[tcc_pkg::PIN_EXT] = ext_count_pin;
    // the pin is sampled whoever drives it, own port output included
    assign pin_raw[tcc_pkg::PIN_CAPTURE] = capture_pin;
    assign pin_raw[tcc_pkg::PIN_COMPARATOR] = comparator_out;

    genvar gp;
    generate
        for (gp = 0; gp < tcc_pkg::N_PINS; gp++) begin : g_sync
            always_ff @(posedge clk) begin
                if (!rstn) begin
                    sync1_reg[gp] <= 1'b0;
                    sync2_reg[gp] <= 1'b0;
                end else begin
                    sync1_reg[gp] <= pin_raw[gp];
                    sync2_reg[gp] <= sync1_reg[gp];
                end
            end
        end
    endgenerate

    // ---------------- external count clock ----------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ext_prev_reg <= 1'b0;
        end else begin
            ext_prev_reg <= sync2_reg[tcc_pkg::PIN_EXT];
        end
    end

    assign ext_rise = sync2_reg[tcc_pkg::PIN_EXT] & ~ext_prev_reg;
    assign ext_fall = ~sync2_reg[tcc_pkg::PIN_EXT] & ext_prev_reg;

    always_comb begin
        timer_tick = 1'b0;
        case (clock_select)
            tcc_pkg::CS_STOP: begin
                timer_tick = 1'b0;
            end
            tcc_pkg::CS_SYS: begin
                timer_tick = 1'b1;
            end
            tcc_pkg::CS_EXT_FALL: begin
                timer_tick = ext_fall;
            end
            tcc_pkg::CS_EXT_RISE: begin
                timer_tick = ext_rise;
            end
            default: begin
                timer_tick = presc_tick[
                    2'(clock_select - tcc_pkg::CS_PRE_FIRST)];
            end
        endcase
    end

    // ---------------- capture trigger path ----------------
    assign trig_sync = comparator_trigger_sel
        ? sync2_reg[tcc_pkg::PIN_COMPARATOR]
        : sync2_reg[tcc_pkg::PIN_CAPTURE];

    // history plus the live sample gives four samples; the filter
    // output lags the raw path by exactly four clocks
    always_ff @(posedge clk) begin
        if (!rstn) begin
            filt_hist_reg <= '0;
            filt_out_reg <= 1'b0;
        end else begin
            filt_hist_reg <= {filt_hist_reg[tcc_pkg::FILTER_SAMPLES-3:0],
                trig_sync};
            if (&{trig_sync, filt_hist_reg}
                    || ~|{trig_sync, filt_hist_reg}) begin
                filt_out_reg <= filt_hist_reg[
                    tcc_pkg::FILTER_SAMPLES-2];
            end
        end
    end

    assign trig_level = noise_filter_en ? filt_out_reg
        : trig_sync;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            trig_prev_reg <= 1'b0;
        end else begin
            trig_prev_reg <= trig_level;
        end
    end

    assign trig_rise = trig_level & ~trig_prev_reg;
    assign trig_fall = ~trig_level & trig_prev_reg;
    assign cap_fire = capture_mode_en
        & (capture_rise_sel ? trig_rise : trig_fall);

    // ---------------- counter ----------------
    always_comb begin
        cnt_next = cnt_reg;
        if (cnt_wr) begin
            // a write wins over anything the tick would do
            cnt_next = wide_count_sel ? {temp_reg, wbyte}
                : {cnt_reg[15:8], wbyte};
        end else if (timer_tick) begin
            if (wide_count_sel) begin
                cnt_next = cnt_reg + 16'h0001;
            end else if (ctc_mode && cnt_reg[7:0] == match_a_reg) begin
                cnt_next = {cnt_reg[15:8], tcc_pkg::RST_BYTE};
            end else begin
                cnt_next = {cnt_reg[15:8],
                    8'(cnt_reg[7:0] + 8'h01)};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt_reg <= tcc_pkg::RST_CNT;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign ovf_set = timer_tick & ~cnt_wr & (wide_count_sel
        ? cnt_reg == tcc_pkg::MAX16
        : cnt_reg[7:0] == tcc_pkg::MAX8);

    // blocks compare matches on the first tick after any counter write, stopped or not
    always_ff @(posedge clk) begin
        if (!rstn) begin
            block_reg <= 1'b0;
        end else if (cnt_wr) begin
            block_reg <= 1'b1;
        end else if (timer_tick) begin
            block_reg <= 1'b0;
        end
    end

    // ---------------- compare ----------------
    assign eq_a = wide_count_sel
        ? cnt_reg == {match_b_reg, match_a_reg}
        : cnt_reg[7:0] == match_a_reg;
    assign eq_b = cnt_reg[7:0] == match_b_reg;
    // match A holds the capture in any capture mode
    assign match_a_set = timer_tick & ~block_reg & eq_a
        & ~capture_mode_en;
    assign match_b_set = timer_tick & ~block_reg & eq_b
        & ~wide_count_sel;

    // ---------------- match / capture registers ----------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            match_a_reg <= tcc_pkg::RST_BYTE;
            match_b_reg <= tcc_pkg::RST_BYTE;
        end else if (cap_fire) begin
            // a capture beats a same-cycle software write
            match_a_reg <= cnt_reg[7:0];
            if (wide_count_sel) begin
                match_b_reg <= cnt_reg[15:8];
            end
        end else if (wr && paddr == tcc_pkg::OFS_MATCH_A) begin
            match_a_reg <= wbyte;
            if (wide_count_sel) begin
                match_b_reg <= temp_reg;
            end
        end else if (wr && paddr == tcc_pkg::OFS_MATCH_B
                && !wide_count_sel) begin
            match_b_reg <= wbyte;
        end
    end

    // shared high byte: filled by high writes, latched by low reads
    always_ff @(posedge clk) begin
        if (!rstn) begin
            temp_reg <= tcc_pkg::RST_BYTE;
        end else if (wr && (paddr == tcc_pkg::OFS_CNT_HI
                || (paddr == tcc_pkg::OFS_MATCH_B
                && wide_count_sel))) begin
            temp_reg <= wbyte;
        end else if (rd_setup && paddr == tcc_pkg::OFS_CNT_LO) begin
            temp_reg <= cnt_reg[15:8];
        end else if (rd_setup && wide_capture
                && paddr == tcc_pkg::OFS_MATCH_A) begin
            temp_reg <= match_b_reg;
        end
    end

    // ---------------- flags ----------------
    assign flag_set[tcc_pkg::FL_OVERFLOW] = ovf_set;
    assign flag_set[tcc_pkg::FL_MATCH_A] = match_a_set;
    assign flag_set[tcc_pkg::FL_MATCH_B] = match_b_set;
    assign flag_set[tcc_pkg::FL_CAPTURE] = cap_fire;

    genvar gf;
    generate
        for (gf = 0; gf < tcc_pkg::FL_W; gf++) begin : g_flag
            assign flag_w1c[gf] = wr && paddr == tcc_pkg::OFS_FLAGS
                && pwdata[gf];
            // a new event in the clearing cycle survives
            assign flag_next[gf] = flag_set[gf]
                | (flag_reg[gf] & ~(flag_w1c[gf]
                | irq_ack[gf]));
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!rstn) begin
            flag_reg <= '0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            irq_req_reg <= '0;
        end else begin
            irq_req_reg <= flag_next & irq_en_reg;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq_req = irq_req_reg;

endmodule : tcc_timer

/* verification/tcc_event_src.sv */
`timescale 1ns/1ps
module tcc_event_src (
    input wire logic clk,
    input wire logic rstn,
    input wire logic cap_level,
    input wire logic cmp_level,
    input wire logic ext_level,
    output logic capture_pin,
    output logic comparator_out,
    output logic ext_count_pin
);
    // levels move on clock edges only, so each lasts whole cycles
    always_ff @(posedge clk) begin
        if (!rstn) begin
            capture_pin <= 1'b0;
            comparator_out <= 1'b0;
            ext_count_pin <= 1'b0;
        end else begin
            capture_pin <= cap_level;
            comparator_out <= cmp_level;
            ext_count_pin <= ext_level;
        end
    end
endmodule : tcc_event_src

/* verification/tcc_timer_props.sv */
`timescale 1ns/1ps
module tcc_timer_props #(
    parameter int PRESC_TAPS = 4
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [PRESC_TAPS-1:0] presc_tick,
    input wire logic ext_count_pin,
    input wire logic capture_pin,
    input wire logic comparator_out,
    input wire logic [tcc_pkg::FL_W-1:0] irq_ack,
    input wire logic [tcc_pkg::FL_W-1:0] irq_req
);
    // cycles since a trigger moved or software wrote; a capture irq
    // with neither as cause is a spurious one
    logic [3:0] calm_reg;
    always_ff @(posedge clk) begin
        if (!rstn || (psel && pwrite) || $changed(capture_pin)
            || $changed(comparator_out)) begin
            calm_reg <= 4'h0;
        end else if (calm_reg != 4'hf) begin
            calm_reg <= calm_reg + 4'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    chk_ready_setup:
        assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    chk_ready_pulse:
        assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_ready_cause:
        assert property (pready |-> $past(psel) && !$past(penable))
        else $error("ready without setup");
    chk_err_ready:
        assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_err_data:
        assert property (pready && pslverr && !pwrite
            |-> prdata == 32'h0000_0000)
        else $error("refused read returns data");
    chk_reset_quiet:
        assert property (@(posedge clk) disable iff (1'b0)
            !rstn |=> irq_req == 4'h0 && !pready)
        else $error("outputs active after reset");
    chk_capture_cause:
        assert property ($rose(irq_req[3]) |-> calm_reg < 4'hc)
        else $error("capture irq without event");
    chk_ack_clears:
        assert property (irq_ack[3] && calm_reg > 4'hb |=> !irq_req[3])
        else $error("capture irq not cleared");
    cover property ($rose(irq_req[3]));
    cover property (pready && pslverr);
    cover property (irq_ack[3] && irq_req[3]);
endmodule : tcc_timer_props

bind tcc_timer tcc_timer_props #(.PRESC_TAPS(PRESC_TAPS)) i_tcc_timer_props (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .presc_tick(presc_tick),
    .ext_count_pin(ext_count_pin), .capture_pin(capture_pin),
    .comparator_out(comparator_out), .irq_ack(irq_ack),
    .irq_req(irq_req)
);

/* verification/testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic clk, rstn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] presc_tick, irq_ack, irq_req;
    logic cap_level, cmp_level, ext_level, cap_pin, cmp_out, ext_pin;
    int n_errors;
    int comparisons;
    tcc_timer #(.PRESC_TAPS(4)) i_tcc_timer (
        .clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .presc_tick(presc_tick), .ext_count_pin(ext_pin),
        .capture_pin(cap_pin), .comparator_out(cmp_out),
        .irq_ack(irq_ack), .irq_req(irq_req)
    );
    tcc_event_src i_tcc_event_src (
        .clk(clk), .rstn(rstn), .cap_level(cap_level),
        .cmp_level(cmp_level), .ext_level(ext_level),
        .capture_pin(cap_pin), .comparator_out(cmp_out),
        .ext_count_pin(ext_pin)
    );
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task print_verdict;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict
    task check(input string name, input logic [31:0] seen,
               input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // one idle edge first, so a release never meets the next request
    task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 16) begin
            @(posedge clk);
            n++;
        end
        if (n == 16) begin
            n_errors++;
            print_verdict();
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task rc(input string name, input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        check(name, rd, {24'h00_0000, e});
    endtask : rc
    task idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle
    task ticks(input int n);
        repeat (n) begin
            @(posedge clk);
            presc_tick <= 4'h1;
            @(posedge clk);
            presc_tick <= 4'h0;
        end
    endtask : ticks
    initial begin
        #200000;
        n_errors++;
        print_verdict();
    end
    initial begin
        {rstn, psel, penable, pwrite, cap_level, cmp_level} = 6'h00;
        {paddr, pwdata, presc_tick, irq_ack, ext_level} = 49'h0;
        n_errors = 0;
        comparisons = 0;
        idle(12);
        rstn <= 1'b1;
        for (int i = 0; i < 8; i++) rc("reset", 8'(i * 4), 8'h00);
        rc("unmapped", 8'h20, 8'h00);
        wr(tcc_pkg::OFS_CNT_LO, 8'h5a);
        ticks(3);
        rc("stopped", tcc_pkg::OFS_CNT_LO, 8'h5a);
        wr(tcc_pkg::OFS_MATCH_A, 8'hff);
        wr(tcc_pkg::OFS_MATCH_B, 8'h00);
        wr(tcc_pkg::OFS_IRQ_EN, 8'h0f);
        wr(tcc_pkg::OFS_CNT_LO, 8'hfe);
        wr(tcc_pkg::OFS_CTRL_B, 8'h02);
        ticks(3);
        rc("wrap", tcc_pkg::OFS_CNT_LO, 8'h01);
        rc("flags", tcc_pkg::OFS_FLAGS, 8'h07);
        check("irq", {28'h000_0000, irq_req}, 32'h0000_0007);
        wr(tcc_pkg::OFS_FLAGS, 8'h01);
        rc("w1c", tcc_pkg::OFS_FLAGS, 8'h06);
        @(posedge clk) irq_ack <= 4'h2;
        @(posedge clk) irq_ack <= 4'h0;
        rc("ack", tcc_pkg::OFS_FLAGS, 8'h04);
        wr(tcc_pkg::OFS_FLAGS, 8'h0f);
        wr(tcc_pkg::OFS_MATCH_A, 8'h10);
        wr(tcc_pkg::OFS_CNT_LO, 8'h10);
        ticks(1);
        rc("blocked", tcc_pkg::OFS_FLAGS, 8'h00);
        wr(tcc_pkg::OFS_CNT_LO, 8'h0f);
        ticks(2);
        rc("match", tcc_pkg::OFS_FLAGS, 8'h02);
        wr(tcc_pkg::OFS_FLAGS, 8'h0f);
        wr(tcc_pkg::OFS_CTRL_A, 8'h01);
        wr(tcc_pkg::OFS_MATCH_A, 8'h03);
        wr(tcc_pkg::OFS_CNT_LO, 8'h00);
        ticks(5);
        rc("ctc", tcc_pkg::OFS_CNT_LO, 8'h01);
        rc("ctc flags", tcc_pkg::OFS_FLAGS, 8'h06);
        wr(tcc_pkg::OFS_FLAGS, 8'h0f);
        wr(tcc_pkg::OFS_CTRL_A, 8'h10);
        wr(tcc_pkg::OFS_CNT_HI, 8'h01);
        wr(tcc_pkg::OFS_CNT_LO, 8'hff);
        ticks(1);
        rc("wide lo", tcc_pkg::OFS_CNT_LO, 8'h00);
        rc("wide hi", tcc_pkg::OFS_CNT_HI, 8'h02);
        rc("no ovf", tcc_pkg::OFS_FLAGS, 8'h00);
        wr(tcc_pkg::OFS_CNT_HI, 8'hff);
        wr(tcc_pkg::OFS_CNT_LO, 8'hff);
        ticks(1);
        rc("wide ovf", tcc_pkg::OFS_FLAGS, 8'h01);
        wr(tcc_pkg::OFS_FLAGS, 8'h0f);
        wr(tcc_pkg::OFS_CTRL_B, 8'h00);
        wr(tcc_pkg::OFS_CTRL_A, 8'h0a);
        wr(tcc_pkg::OFS_CNT_LO, 8'h42);
        cap_level <= 1'b1;
        idle(12);
        rc("capture", tcc_pkg::OFS_MATCH_A, 8'h42);
        check("cap irq", {28'h000_0000, irq_req}, 32'h0000_0008);
        @(posedge clk) irq_ack <= 4'h8;
        @(posedge clk) irq_ack <= 4'h0;
        rc("cap ack", tcc_pkg::OFS_FLAGS, 8'h00);
        cap_level <= 1'b0;
        idle(12);
        rc("fall", tcc_pkg::OFS_FLAGS, 8'h00);
        wr(tcc_pkg::OFS_CNT_LO, 8'h43);
        cap_level <= 1'b1;
        idle(12);
        rc("overwrite", tcc_pkg::OFS_MATCH_A, 8'h43);
        wr(tcc_pkg::OFS_MATCH_B, 8'h77);
        rc("free b", tcc_pkg::OFS_MATCH_B, 8'h77);
        wr(tcc_pkg::OFS_CTRL_B, 8'h08);
        cap_level <= 1'b0;
        idle(12);
        wr(tcc_pkg::OFS_FLAGS, 8'h0f);
        wr(tcc_pkg::OFS_CNT_LO, 8'h50);
        cap_level <= 1'b1;
        idle(2);
        cap_level <= 1'b0;
        idle(12);
        rc("glitch", tcc_pkg::OFS_FLAGS, 8'h00);
        cap_level <= 1'b1;
        idle(12);
        rc("filtered", tcc_pkg::OFS_MATCH_A, 8'h50);
        wr(tcc_pkg::OFS_CTRL_A, 8'h0e);
        wr(tcc_pkg::OFS_FLAGS, 8'h0f);
        wr(tcc_pkg::OFS_CNT_LO, 8'h61);
        cmp_level <= 1'b1;
        idle(12);
        rc("comparator", tcc_pkg::OFS_MATCH_A, 8'h61);
        wr(tcc_pkg::OFS_CTRL_B, 8'h00);
        wr(tcc_pkg::OFS_CTRL_A, 8'h1a);
        cap_level <= 1'b0;
        idle(12);
        wr(tcc_pkg::OFS_FLAGS, 8'h0f);
        wr(tcc_pkg::OFS_CNT_HI, 8'h12);
        wr(tcc_pkg::OFS_CNT_LO, 8'h34);
        cap_level <= 1'b1;
        idle(12);
        rc("cap lo", tcc_pkg::OFS_MATCH_A, 8'h34);
        rc("cap hi", tcc_pkg::OFS_MATCH_B, 8'h12);
        wr(tcc_pkg::OFS_CTRL_A, 8'h00);
        wr(tcc_pkg::OFS_CTRL_B, 8'h07);
        wr(tcc_pkg::OFS_CNT_LO, 8'h00);
        for (int i = 0; i < 3; i++) begin
            ext_level <= ~ext_level;
            idle(6);
        end
        rc("ext count", tcc_pkg::OFS_CNT_LO, 8'h02);
        // system clock select counts on the three edges up to the stop
        wr(tcc_pkg::OFS_CTRL_B, 8'h01);
        wr(tcc_pkg::OFS_CTRL_B, 8'h00);
        rc("sys clock", tcc_pkg::OFS_CNT_LO, 8'h05);
        wr(tcc_pkg::OFS_CTRL_B, 8'h06);
        ext_level <= ~ext_level;
        idle(6);
        rc("ext fall", tcc_pkg::OFS_CNT_LO, 8'h06);
        print_verdict();
    end
endmodule : testbench
